// ==== rtl/icd_regs.svh ====
`ifndef ICD_REGS_SVH
`define ICD_REGS_SVH
// ----------------------------------------
// clock and serial rate
// ----------------------------------------
`define ICD_CLK_HZ 50000000
`define ICD_BAUD 9600
`define ICD_BAUD_CYC (`ICD_CLK_HZ / `ICD_BAUD)
// ----------------------------------------
// frequency measurement
// ----------------------------------------
`define ICD_GATE_MS 100
`define ICD_GATE_CYC ((`ICD_CLK_HZ / 1000) * `ICD_GATE_MS)
`define ICD_DROP_HZ 130
`define ICD_DROP_CNT 16'((`ICD_DROP_HZ * `ICD_GATE_MS) / 1000)
`define ICD_SETPT_CNT 16'h0003
`define ICD_DEAD_CNT 16'h0064
// ----------------------------------------
// timers in seconds
// ----------------------------------------
`define ICD_SEC_CYC `ICD_CLK_HZ
`define ICD_HOLD_S 8'h3C
`define ICD_HEAT_MAX_S 8'h19
`define ICD_EXTRA_S 8'h02
`define ICD_COOL_S 8'h03
// ----------------------------------------
// report string
// ----------------------------------------
`define ICD_RPT_CHARS 5'h18
`define ICD_ASCII_0 8'h30
`define ICD_ASCII_A 8'h37
`endif

// ==== rtl/icd_pkg.sv ====
`default_nettype none
package icd_pkg;
   timeunit 1ns;
   timeprecision 1ps;
   typedef enum logic [1:0] {ST_MON, ST_HEAT, ST_EXTRA, ST_COOL} icd_state_t;
   // report snapshot: 12 bytes, sent as 24 hex characters, msb first
   typedef struct packed {
      logic [7:0] heater;
      logic [7:0] ice;
      logic [7:0] fail;
      logic [7:0] errs;
      logic [15:0] freq;
      logic [15:0] ref_cnt;
      logic [15:0] ice_cnt;
      logic [7:0] hold_s;
      logic [7:0] state;
   } icd_rpt_t;
   typedef struct packed {
      logic drive_o;
      logic oe_o;
   } icd_od_t;
endpackage : icd_pkg
`default_nettype wire

// ==== rtl/icd_uart_tx.sv ====
`default_nettype none
module icd_uart_tx #(
   parameter int BAUD_CYC = 5208
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // character in
   input wire logic [7:0] data_i,
   input wire logic valid_i,
   output logic ready_o,
   // line
   output logic txd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cnt_r;
   logic [3:0] bit_r;
   logic [9:0] sh_r;
   wire busy = (bit_r != 4'h0);
   wire tick = (cnt_r == 32'(BAUD_CYC - 1));
   assign ready_o = !busy;
   // frame: start 0, eight data lsb first, stop 1, no parity
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 32'h0;
         bit_r <= 4'h0;
         sh_r <= 10'h3FF;
      end else if (!busy) begin
         cnt_r <= 32'h0;
         if (valid_i) begin
            sh_r <= {1'b1, data_i, 1'b0};
            bit_r <= 4'hA;
         end
      end else if (tick) begin
         cnt_r <= 32'h0;
         sh_r <= {1'b1, sh_r[9:1]};
         bit_r <= bit_r - 4'h1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
   assign txd_o = sh_r[0];
endmodule : icd_uart_tx
`default_nettype wire

// ==== rtl/icd_top.sv ====
`include "icd_regs.svh"
`default_nettype none
module icd_top #(
   parameter int GATE_CYC = `ICD_GATE_CYC,
   parameter int SEC_CYC = `ICD_SEC_CYC,
   parameter int BAUD_CYC = `ICD_BAUD_CYC
) (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   // probe and supply monitor
   input wire logic PROBE_OSC_I,
   input wire logic PWR_FAULT_I,
   input wire logic PWR_INTR_I,
   // heater
   output logic HEATER_O,
   // open-drain discrete lines
   output logic ICE_O,
   output logic ICE_OE_O,
   output logic STAT_O,
   output logic STAT_OE_O,
   // serial report
   output logic TXD_O
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // reset release and input synchronisers
   // ----------------------------------------
   logic [1:0] rst_q;
   wire rst_n = rst_q[1];
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) rst_q <= 2'b00;
      else rst_q <= {rst_q[0], 1'b1};
   end

   logic [2:0] osc_q, flt_q, int_q;
   logic osc_r, flt_r, int_r;
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         osc_q <= 3'h0;
         flt_q <= 3'h0;
         int_q <= 3'h0;
         osc_r <= 1'b0;
         flt_r <= 1'b0;
         int_r <= 1'b0;
      end else begin
         osc_q <= {osc_q[1:0], PROBE_OSC_I};
         flt_q <= {flt_q[1:0], PWR_FAULT_I};
         int_q <= {int_q[1:0], PWR_INTR_I};
         if (osc_q[1] == osc_q[2]) osc_r <= osc_q[2];
         if (flt_q[1] == flt_q[2]) flt_r <= flt_q[2];
         if (int_q[1] == int_q[2]) int_r <= int_q[2];
      end
   end

   // halted logic keeps its counters, timers and state while heater_r clears and a character in flight completes, so status survives an interruption
   wire run = !flt_r && !int_r;

   // ----------------------------------------
   // gate and one-second enables
   // ----------------------------------------
   logic [31:0] gate_r, sec_r;
   wire gate_end = run && (gate_r == 32'(GATE_CYC - 1));
   wire sec_en = run && (sec_r == 32'(SEC_CYC - 1));
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         gate_r <= 32'h0;
         sec_r <= 32'h0;
      end else if (run) begin
         gate_r <= gate_end ? 32'h0 : gate_r + 32'h1;
         sec_r <= sec_en ? 32'h0 : sec_r + 32'h1;
      end
   end

   // ----------------------------------------
   // frequency count and reference
   // ----------------------------------------
   logic osc_d_r;
   logic [15:0] cnt_r, meas_r, ref_r;
   logic ref_ok_r, meas_v_r, dead_r;
   wire osc_rise = osc_r && !osc_d_r;
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         osc_d_r <= 1'b0;
         cnt_r <= 16'h0;
         meas_r <= 16'h0;
         meas_v_r <= 1'b0;
      end else begin
         osc_d_r <= osc_r;
         meas_v_r <= gate_end;
         if (gate_end) begin
            meas_r <= cnt_r;
            cnt_r <= 16'(osc_rise);
         end else if (run && osc_rise && cnt_r != 16'hFFFF) begin
            cnt_r <= cnt_r + 16'h1;
         end
      end
   end

   icd_pkg::icd_state_t st_r, st_nxt;
   wire [15:0] drop = ref_r - meas_r;
   wire below = ref_ok_r && (meas_r < ref_r);
   // a dead probe reads as a failure, never as ice
   wire ice_evt = meas_v_r && (st_r == icd_pkg::ST_MON) && below
                  && (drop >= `ICD_DROP_CNT) && (meas_r >= `ICD_DEAD_CNT);
   wire at_setpt = meas_v_r && (meas_r + `ICD_SETPT_CNT >= ref_r);

   // ice-free reference follows the highest reading seen while monitoring
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ref_r <= 16'h0;
         ref_ok_r <= 1'b0;
         dead_r <= 1'b0;
      end else if (meas_v_r) begin
         dead_r <= (meas_r < `ICD_DEAD_CNT);
         if (st_r == icd_pkg::ST_MON && (!ref_ok_r || meas_r > ref_r)
             && meas_r >= `ICD_DEAD_CNT) begin
            ref_r <= meas_r;
            ref_ok_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // de-icing sequence
   // ----------------------------------------
   logic [7:0] heat_s_r, wait_s_r;
   logic heat_to_r;
   wire heat_cap = (heat_s_r >= `ICD_HEAT_MAX_S - 8'h1) && sec_en;
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         icd_pkg::ST_MON: if (ice_evt) st_nxt = icd_pkg::ST_HEAT;
         icd_pkg::ST_HEAT: begin
            if (heat_cap) st_nxt = icd_pkg::ST_COOL;
            else if (at_setpt) st_nxt = icd_pkg::ST_EXTRA;
         end
         icd_pkg::ST_EXTRA: begin
            if (heat_cap) st_nxt = icd_pkg::ST_COOL;
            else if (sec_en && wait_s_r >= `ICD_EXTRA_S - 8'h1)
               st_nxt = icd_pkg::ST_COOL;
         end
         icd_pkg::ST_COOL: begin
            if (sec_en && wait_s_r >= `ICD_COOL_S - 8'h1)
               st_nxt = icd_pkg::ST_MON;
         end
      endcase
   end

   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= icd_pkg::ST_MON;
         heat_s_r <= 8'h0;
         wait_s_r <= 8'h0;
         heat_to_r <= 1'b0;
      end else if (run) begin
         st_r <= st_nxt;
         if (st_r == icd_pkg::ST_MON) heat_s_r <= 8'h0;
         else if (sec_en && st_r != icd_pkg::ST_COOL) heat_s_r <= heat_s_r + 8'h1;
         if (st_nxt != st_r) wait_s_r <= 8'h0;
         else if (sec_en) wait_s_r <= wait_s_r + 8'h1;
         if (heat_cap && st_r == icd_pkg::ST_HEAT) heat_to_r <= 1'b1;
         else if (st_r == icd_pkg::ST_HEAT && at_setpt) heat_to_r <= 1'b0;
      end
   end

   logic heater_r;
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) heater_r <= 1'b0;
      else heater_r <= run && (st_nxt == icd_pkg::ST_HEAT || st_nxt == icd_pkg::ST_EXTRA);
   end
   assign HEATER_O = heater_r;

   // ----------------------------------------
   // ice hold timer
   // ----------------------------------------
   // resolution is the shared one-second enable, so the hold ends up to 1 s early
   logic [7:0] hold_r;
   logic [15:0] ice_cnt_r;
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         hold_r <= 8'h0;
         ice_cnt_r <= 16'h0;
      end else if (ice_evt) begin
         hold_r <= `ICD_HOLD_S;
         ice_cnt_r <= ice_cnt_r + 16'h1;
      end else if (sec_en && hold_r != 8'h0) begin
         hold_r <= hold_r - 8'h1;
      end
   end
   wire ice_on = (hold_r != 8'h0);
   wire fail = flt_r || dead_r;

   // ----------------------------------------
   // discrete lines
   // ----------------------------------------
   logic ice_oe_r, stat_oe_r;
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ice_oe_r <= 1'b0;
         stat_oe_r <= 1'b0;
      end else begin
         ice_oe_r <= ice_on;
         stat_oe_r <= !fail;
      end
   end
   assign ICE_O = 1'b0;
   assign ICE_OE_O = ice_oe_r;
   assign STAT_O = 1'b0;
   assign STAT_OE_O = stat_oe_r;

   // ----------------------------------------
   // serial report
   // ----------------------------------------
   icd_pkg::icd_rpt_t snap_r, snap_nxt;
   logic [4:0] chr_r;
   logic sending_r;
   logic tx_ready;
   always_comb begin
      snap_nxt.heater = {7'h0, heater_r};
      snap_nxt.ice = {7'h0, ice_on};
      snap_nxt.fail = {7'h0, fail};
      snap_nxt.errs = {5'h0, heat_to_r, dead_r, flt_r};
      snap_nxt.freq = meas_r;
      snap_nxt.ref_cnt = ref_r;
      snap_nxt.ice_cnt = ice_cnt_r;
      snap_nxt.hold_s = hold_r;
      snap_nxt.state = {6'h0, st_r};
   end
   wire [95:0] snap_bits = snap_r;
   wire [6:0] nib_lo = 7'(({2'b0, `ICD_RPT_CHARS} - 7'h1 - {2'b0, chr_r}) * 7'h4);
   wire [3:0] nib = snap_bits[nib_lo +: 4];
   wire [7:0] chr = (nib < 4'hA) ? `ICD_ASCII_0 + {4'h0, nib}
                                 : `ICD_ASCII_A + {4'h0, nib};
   // no new character starts while halted; a character in flight completes
   wire tx_valid = sending_r && run;
   always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
         snap_r <= '0;
         chr_r <= 5'h0;
         sending_r <= 1'b0;
      end else if (!sending_r) begin
         if (sec_en) begin
            snap_r <= snap_nxt;
            chr_r <= 5'h0;
            sending_r <= 1'b1;
         end
      end else if (tx_valid && tx_ready) begin
         if (chr_r == `ICD_RPT_CHARS - 5'h1) sending_r <= 1'b0;
         chr_r <= chr_r + 5'h1;
      end
   end

   icd_uart_tx #(
      .BAUD_CYC(BAUD_CYC)
   ) u_tx (
      .clk_i(MCLK_I),
      .rst_n_i(rst_n),
      .data_i(chr),
      .valid_i(tx_valid),
      .ready_o(tx_ready),
      .txd_o(TXD_O)
   );
endmodule : icd_top
`default_nettype wire

// ==== testbench/icd_monitor.sv ====
`default_nettype none
module icd_monitor #(
   parameter int GATE_CYC = 1200,
   parameter int SEC_CYC = 1000,
   parameter int BAUD_CYC = 4
) (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   // inputs and outputs of the top module
   input wire logic PROBE_OSC_I,
   input wire logic PWR_FAULT_I,
   input wire logic PWR_INTR_I,
   input wire logic HEATER_O,
   input wire logic ICE_O,
   input wire logic ICE_OE_O,
   input wire logic STAT_O,
   input wire logic STAT_OE_O,
   input wire logic TXD_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] heat_run_r;
   logic [31:0] ice_run_r;
   logic [31:0] low_run_r;
   // run lengths stand in for long repetitions, which the tools cannot unroll
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         heat_run_r <= '0;
         ice_run_r <= '0;
         low_run_r <= '0;
      end else begin
         heat_run_r <= HEATER_O ? heat_run_r + 32'h1 : '0;
         ice_run_r <= ICE_OE_O ? ice_run_r + 32'h1 : '0;
         low_run_r <= TXD_O ? '0 : low_run_r + 32'h1;
      end
   end
   default clocking mon_cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_B_I);
   a_ice_drive_low: assert property (ICE_O == 1'b0)
      else $error("ice line driven high");
   a_stat_drive_low: assert property (STAT_O == 1'b0)
      else $error("status line driven high");
   a_fault_shows_fail: assert property (PWR_FAULT_I [*8] |-> !STAT_OE_O)
      else $error("status held healthy during power fault");
   a_heat_flags_ice: assert property ($rose(HEATER_O) |-> ##[0:2] ICE_OE_O)
      else $error("heater on without ice indication");
   a_heat_time_cap: assert property (heat_run_r <= 26 * SEC_CYC)
      else $error("heating period too long");
   a_ice_hold_min: assert property ($fell(ICE_OE_O) |-> ice_run_r >= 59 * SEC_CYC - 2)
      else $error("ice indication ended early");
   a_bit_whole_len: assert property ($rose(TXD_O) |->
      (low_run_r % BAUD_CYC == 0) && (low_run_r <= 9 * BAUD_CYC))
      else $error("serial low run not whole bits");
   a_intr_keeps_stat: assert property (PWR_INTR_I [*8] ##0 (STAT_OE_O && !PWR_FAULT_I)
      |=> STAT_OE_O)
      else $error("status lost during interruption");
endmodule : icd_monitor
bind icd_top icd_monitor #(
   .GATE_CYC(GATE_CYC),
   .SEC_CYC(SEC_CYC),
   .BAUD_CYC(BAUD_CYC)
) icd_monitor_inst (
   .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .PROBE_OSC_I(PROBE_OSC_I),
   .PWR_FAULT_I(PWR_FAULT_I), .PWR_INTR_I(PWR_INTR_I), .HEATER_O(HEATER_O),
   .ICE_O(ICE_O), .ICE_OE_O(ICE_OE_O), .STAT_O(STAT_O), .STAT_OE_O(STAT_OE_O),
   .TXD_O(TXD_O)
);
`default_nettype wire

// ==== testbench/icd_logger.sv ====
`default_nettype none
module icd_logger #(
   parameter int BAUD_CYC = 4
) (
   // clock and serial line
   input wire logic clk_i,
   input wire logic txd_i,
   // open-drain discrete lines
   input wire icd_pkg::icd_od_t ice_od_i,
   input wire icd_pkg::icd_od_t stat_od_i,
   output logic ice_line_o,
   output logic stat_line_o,
   // decoded report
   output logic [7:0] rpt_ice_o = 8'hFF,
   output logic [7:0] rpt_fail_o = 8'hFF,
   output var int rpt_cnt_o = 0,
   output var int chr_cnt_o = 0,
   output var int frm_err_o = 0,
   output var int hex_err_o = 0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] line_r [0:23];
   int idx = 0;
   int idle = 0;
   // pull-ups on the logger side: a released line reads high
   assign ice_line_o = ice_od_i.oe_o ? ice_od_i.drive_o : 1'b1;
   assign stat_line_o = stat_od_i.oe_o ? stat_od_i.drive_o : 1'b1;
   function automatic logic [4:0] nib(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
      if (c >= 8'h41 && c <= 8'h46) return {1'b0, c[3:0] + 4'h9};
      return 5'h10;
   endfunction : nib
   // ones inside a report never run for four bit times (hex digits keep bit 7 low),
   // while the gap between reports does: a gap restarts the count, so a string
   // cut by an interruption cannot shift every report after it
   always @(posedge clk_i) begin
      idle = txd_i ? idle + 1 : 0;
      if (idle == 4 * BAUD_CYC) idx = 0;
   end
   initial begin
      forever begin : rx_chr
         logic [7:0] b;
         @(negedge txd_i);
         repeat (BAUD_CYC / 2) @(posedge clk_i);
         if (txd_i !== 1'b0) frm_err_o++;
         for (int i = 0; i < 8; i++) begin
            repeat (BAUD_CYC) @(posedge clk_i);
            b[i] = txd_i;
         end
         repeat (BAUD_CYC) @(posedge clk_i);
         if (txd_i !== 1'b1) frm_err_o++;
         line_r[idx] = b;
         idx++;
         chr_cnt_o++;
         if (idx == 24) begin
            for (int j = 0; j < 24; j++) if (nib(line_r[j]) > 5'h0F) hex_err_o++;
            rpt_ice_o = 8'(nib(line_r[2]) * 16 + nib(line_r[3]));
            rpt_fail_o = 8'(nib(line_r[4]) * 16 + nib(line_r[5]));
            rpt_cnt_o++;
            idx = 0;
         end
      end
   end
endmodule : icd_logger
`default_nettype wire

// ==== testbench/tb_top.sv ====
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 1000;
   localparam int CEIL = 100000;
   typedef struct packed {
      logic [3:0] half;
      logic [7:0] secs;
      logic heat;
      logic ice_ln;
      logic [7:0] r_ice;
   } icd_row_t;
   logic MCLK_I = 1'b0;
   logic RST_B_I = 1'b0;
   logic PROBE_OSC_I = 1'b0;
   logic PWR_FAULT_I = 1'b0;
   logic PWR_INTR_I = 1'b0;
   logic HEATER_O, ICE_O, ICE_OE_O, STAT_O, STAT_OE_O, TXD_O, ice_ln, stat_ln;
   logic [7:0] r_ice, r_fail;
   logic [3:0] half = 4'h4;
   logic [3:0] pc = 4'h0;
   int r_cnt, c_cnt, f_err, h_err, t0, n;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   // probe period 2*half cycles: 150 counts a gate at half 4, 120 at half 5
   icd_row_t rows [0:2] = '{'{4'h4, 8'h04, 1'b0, 1'b1, 8'h00},
      '{4'h5, 8'h03, 1'b1, 1'b0, 8'hFF}, '{4'h4, 8'h0A, 1'b0, 1'b0, 8'h01}};
   icd_top #(.GATE_CYC(1200), .SEC_CYC(SEC), .BAUD_CYC(4)) icd_top_inst (
      .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .PROBE_OSC_I(PROBE_OSC_I),
      .PWR_FAULT_I(PWR_FAULT_I), .PWR_INTR_I(PWR_INTR_I), .HEATER_O(HEATER_O),
      .ICE_O(ICE_O), .ICE_OE_O(ICE_OE_O), .STAT_O(STAT_O), .STAT_OE_O(STAT_OE_O),
      .TXD_O(TXD_O));
   icd_logger #(.BAUD_CYC(4)) icd_logger_inst (
      .clk_i(MCLK_I), .txd_i(TXD_O), .ice_od_i({ICE_O, ICE_OE_O}),
      .stat_od_i({STAT_O, STAT_OE_O}), .ice_line_o(ice_ln), .stat_line_o(stat_ln),
      .rpt_ice_o(r_ice), .rpt_fail_o(r_fail), .rpt_cnt_o(r_cnt), .chr_cnt_o(c_cnt),
      .frm_err_o(f_err), .hex_err_o(h_err));
   always #10 MCLK_I = ~MCLK_I;
   always @(negedge MCLK_I) begin
      if (half == 4'h0) PROBE_OSC_I <= 1'b0;
      else if (pc >= half - 4'h1) begin
         pc <= 4'h0;
         PROBE_OSC_I <= ~PROBE_OSC_I;
      end else pc <= pc + 4'h1;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   always @(posedge MCLK_I) begin
      cyc <= cyc + 1;
      if (cyc == CEIL) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic wait_cyc(input int k);
      repeat (k) @(negedge MCLK_I);
   endtask : wait_cyc
   initial begin
      wait_cyc(10);
      chk_bit(HEATER_O, 1'b0);
      chk_bit(ice_ln, 1'b1);
      chk_bit(stat_ln, 1'b1);
      chk_bit(TXD_O, 1'b1);
      wait_cyc(6);
      RST_B_I = 1'b1;
      $display("test reset done");
      foreach (rows[k]) begin
         half = rows[k].half;
         wait_cyc(rows[k].secs * SEC);
         chk_bit(HEATER_O, rows[k].heat);
         chk_bit(ice_ln, rows[k].ice_ln);
         chk_bit(stat_ln, 1'b0);
         if (rows[k].r_ice != 8'hFF) begin
            chk_byte(r_ice, rows[k].r_ice);
            chk_byte(r_fail, 8'h00);
         end
         $display("test row %0d done", k);
      end
      // frequency kept low so only the time cap can end the heating
      half = 4'h5;
      for (n = 0; n < 4 * SEC && HEATER_O !== 1'b1; n++) wait_cyc(1);
      t0 = cyc;
      for (n = 0; n < 28 * SEC && HEATER_O !== 1'b0; n++) wait_cyc(1);
      half = 4'h4;
      chk_bit(cyc - t0 >= 24 * SEC && cyc - t0 <= 26 * SEC, 1'b1);
      $display("test heat cap done");
      wait_cyc(t0 + 58 * SEC + SEC / 2 - cyc);
      chk_bit(ice_ln, 1'b0);
      wait_cyc(t0 + 61 * SEC - cyc);
      chk_bit(ice_ln, 1'b1);
      chk_bit(HEATER_O, 1'b0);
      $display("test ice hold done");
      n = c_cnt;
      PWR_INTR_I = 1'b1;
      wait_cyc(3 * SEC / 2);
      chk_bit(c_cnt - n <= 2, 1'b1);
      chk_bit(stat_ln, 1'b0);
      n = r_cnt;
      PWR_INTR_I = 1'b0;
      wait_cyc(2 * SEC);
      chk_bit(r_cnt > n, 1'b1);
      chk_byte(8'(f_err), 8'h00);
      chk_byte(8'(h_err), 8'h00);
      $display("test interruption done");
      half = 4'h0;
      wait_cyc(5 * SEC);
      chk_bit(stat_ln, 1'b1);
      chk_byte(r_fail, 8'h01);
      half = 4'h4;
      wait_cyc(3 * SEC);
      chk_bit(stat_ln, 1'b0);
      PWR_FAULT_I = 1'b1;
      wait_cyc(200);
      chk_bit(stat_ln, 1'b1);
      $display("test failure done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
